// [pbc_pkg.sv]
// constants and types for the per-pin bit control block
// Contract
// [RULE_01] pin function comes from function select, pulse-train enable, direction and data bits
// [RULE_02] as output, function select picks the toggle rate for LED flashing
// [RULE_03] seven fixed flash rates, eight pulse trains, or steady on/off drive
// [RULE_04] flashing drives open-source (high only) or open-drain (low only)
// [RULE_05] per-pin direction and data bits control this pin individually
// [RULE_06] direction bit set tri-states pin as input; cleared makes it an output
// [RULE_07] as input, function select picks which pin edge raises an interrupt
// [RULE_08] filtered valid edge asserts active-low interrupt and loads source with register address
// [RULE_09] software should change direction and enable interrupt in separate writes
// [RULE_10] software emulates open-drain/source by fixing data and toggling direction
// [RULE_11] reset sets direction bit to 1, pin is input with weak pull-up
// [RULE_12] as output, pin is driven to the written data bit
// [RULE_13] as input, data bit read returns live pin level, never stored value
// [RULE_14] unconnected input reads 1 through the weak internal pull-up
// [RULE_15] reset sets stored data bit to 1; reads still return pin level
// [RULE_16] pulse-train enable makes function select choose one of eight pulse trains
// [RULE_17] bit control has lowest priority behind PWM, bypass and fan functions
// [RULE_18] code-to-rate and code-to-edge mappings are supplied as parameter tables
package pbc_pkg;

    // register map
    localparam logic [7:0] PBC_BASE_ADDR  = 8'hc0;
    localparam logic [7:0] PBC_RST_VAL    = 8'h03;
    localparam logic [7:0] PBC_WR_MASK    = 8'h9f;
    localparam int         PBC_PTE_POS    = 7;
    localparam int         PBC_FS_LSB     = 2;
    localparam int         PBC_FS_MSB     = 4;
    localparam int         PBC_DD_POS     = 1;
    localparam int         PBC_GPD_POS    = 0;

    // timing
    localparam int         PBC_CLK_NS     = 100;
    localparam int         PBC_CYC_PER_MS = 1_000_000 / PBC_CLK_NS;
    localparam int         PBC_FILT_NS    = 300;
    localparam int         PBC_FILT_RAW   = (PBC_FILT_NS + PBC_CLK_NS - 1) / PBC_CLK_NS;
    localparam int         PBC_FILT_CYC   = (PBC_FILT_RAW < 1) ? 1 : PBC_FILT_RAW;

    // flash half periods in ms, codes 1..7
    localparam int         PBC_FLASH1_MS  = 1000;
    localparam int         PBC_FLASH2_MS  = 500;
    localparam int         PBC_FLASH3_MS  = 250;
    localparam int         PBC_FLASH4_MS  = 125;
    localparam int         PBC_FLASH5_MS  = 64;
    localparam int         PBC_FLASH6_MS  = 32;
    localparam int         PBC_FLASH7_MS  = 16;
    localparam int         PBC_CNT_W      = 24;
    localparam logic [7*PBC_CNT_W-1:0] PBC_FLASH_HALF_CYC = {
        24'(PBC_FLASH7_MS * PBC_CYC_PER_MS), 24'(PBC_FLASH6_MS * PBC_CYC_PER_MS),
        24'(PBC_FLASH5_MS * PBC_CYC_PER_MS), 24'(PBC_FLASH4_MS * PBC_CYC_PER_MS),
        24'(PBC_FLASH3_MS * PBC_CYC_PER_MS), 24'(PBC_FLASH2_MS * PBC_CYC_PER_MS),
        24'(PBC_FLASH1_MS * PBC_CYC_PER_MS)};

    // edge table, 2 bits per code {rise, fall}
    localparam logic [15:0] PBC_EDGE_TABLE = 16'hf6d8;

    typedef enum logic [3:0] {
        PBC_DRV_INPUT  = 4'b0001,
        PBC_DRV_STEADY = 4'b0010,
        PBC_DRV_FLASH  = 4'b0100,
        PBC_DRV_TRAIN  = 4'b1000
    } pbc_drive_t;

endpackage

// [pbc_edge_filter.sv]
// transition filter: accepts a level after it stays stable, or at once without a pulse on rearm, pulses on stable edges
`timescale 1ns/10ps
module pbc_edge_filter #(
    parameter int FILT_CYC = 3
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic level_in,
    input  wire logic rearm,
    output logic      filt_level,
    output logic      rise_pulse,
    output logic      fall_pulse
);
    localparam int CW = $clog2(FILT_CYC + 1);

    logic          stable_ff;
    logic [CW-1:0] cnt_ff;
    logic          rise_ff;
    logic          fall_ff;
    logic          differs;
    logic          accept;

    assign differs    = level_in != stable_ff;
    assign accept     = differs && (cnt_ff == CW'(FILT_CYC - 1));
    assign filt_level = stable_ff;
    assign rise_pulse = rise_ff;
    assign fall_pulse = fall_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_ff <= 1'b1;
            cnt_ff    <= '0;
            rise_ff   <= 1'b0;
            fall_ff   <= 1'b0;
        end else begin
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
            if (rearm) begin
                stable_ff <= level_in;
                cnt_ff    <= '0;
            end else if (!differs) begin
                cnt_ff <= '0;
            end else if (accept) begin
                stable_ff <= level_in;
                cnt_ff    <= '0;
                rise_ff   <= level_in;
                fall_ff   <= ~level_in;
            end else begin
                cnt_ff <= cnt_ff + CW'(1);
            end
        end
    end
endmodule

// [pbc_pin_ctrl.sv]
// per-pin bit control: control register, flash and pulse-train drive, edge interrupt
`timescale 1ns/10ps
module pbc_pin_ctrl
    import pbc_pkg::*;
#(
    parameter logic [2:0]                 PIN_INDEX      = 3'h0,
    parameter logic [7*pbc_pkg::PBC_CNT_W-1:0] FLASH_HALF_CYC = pbc_pkg::PBC_FLASH_HALF_CYC,
    parameter logic [15:0]                EDGE_TABLE     = pbc_pkg::PBC_EDGE_TABLE,
    parameter int                         FILT_CYC       = pbc_pkg::PBC_FILT_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rd_valid,
    input  wire logic [7:0] pulse_train_in,
    input  wire logic       override_en,
    input  wire logic       override_out,
    input  wire logic       override_oe_n,
    input  wire logic       pin_in,
    output logic            pin_out,
    output logic            pin_oe_n,
    output logic            pin_pullup_en,
    input  wire logic       int_clear,
    output logic            int_n,
    output logic      [7:0] int_src,
    output logic            int_src_load
);
    import pbc_pkg::*;

    localparam logic [7:0] MY_ADDR = PBC_BASE_ADDR + {5'h00, PIN_INDEX};

    ////////////////////////////////////////////////////////////////////////////////
    // register access

    logic [7:0]  ctrl_ff;
    logic [7:0]  rdata_ff;
    logic        rd_valid_ff;
    logic        wr_hit;
    logic        rd_hit;
    logic        ctl_pte;
    logic [2:0]  ctl_fs;
    logic        ctl_dd;
    logic        ctl_gpd;
    logic [7:0]  nxt_ctrl;
    logic [7:0]  rd_word;
    logic [7:0]  nxt_rdata;
    logic        rd_data_bit;
    logic        dir_change;

    assign wr_hit     = reg_wr_en && (reg_addr == MY_ADDR);
    assign rd_hit     = reg_rd_en && (reg_addr == MY_ADDR);
    assign nxt_ctrl   = reg_wdata & PBC_WR_MASK;
    assign ctl_pte    = ctrl_ff[PBC_PTE_POS];
    assign ctl_fs     = ctrl_ff[PBC_FS_MSB:PBC_FS_LSB];
    assign ctl_dd     = ctrl_ff[PBC_DD_POS];                                       // [RULE_05]
    assign ctl_gpd    = ctrl_ff[PBC_GPD_POS];                                      // [RULE_05]
    assign dir_change = wr_hit && (nxt_ctrl[PBC_DD_POS] != ctl_dd);

    // bits 6:5 are dropped on write and read back as zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= PBC_RST_VAL;                                                // [RULE_11] [RULE_15]
        end else if (wr_hit) begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin input synchroniser and read-back

    // two-flop synchroniser, reset high to match the pulled-up idle pin
    logic pin_meta_ff;
    logic pin_sync_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_ff <= 1'b1;
            pin_sync_ff <= 1'b1;
        end else begin
            pin_meta_ff <= pin_in;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign rd_data_bit = ctl_dd ? pin_sync_ff : ctl_gpd;                          // [RULE_13] [RULE_15]
    assign rd_word     = {ctl_pte, 2'b00, ctl_fs, ctl_dd, rd_data_bit};
    assign nxt_rdata   = rd_hit ? rd_word : 8'h00;

    // reads answer one cycle after the hit, zero otherwise
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_hit;
        end
    end

    assign reg_rdata    = rdata_ff;
    assign reg_rd_valid = rd_valid_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // drive mode decode

    pbc_drive_t drive_mode;
    logic       sel_input;
    logic       sel_train;
    logic       sel_flash;
    logic [2:0] flash_idx;

    // input wins, then pulse train, then fixed flash, else steady drive
    assign sel_input  = ctl_dd;                                                    // [RULE_06]
    assign sel_train  = !ctl_dd && ctl_pte;                                        // [RULE_16]
    assign sel_flash  = !ctl_dd && !ctl_pte && (ctl_fs != 3'h0);                   // [RULE_02]
    assign flash_idx  = (ctl_fs == 3'h0) ? 3'h0 : ctl_fs - 3'h1;
    assign drive_mode = sel_input ? PBC_DRV_INPUT :                                // [RULE_01] [RULE_03]
                        sel_train ? PBC_DRV_TRAIN :
                        sel_flash ? PBC_DRV_FLASH : PBC_DRV_STEADY;

    ////////////////////////////////////////////////////////////////////////////////
    // fixed-rate flash generator

    logic [PBC_CNT_W-1:0] flash_cnt_ff;
    logic                 flash_wave_ff;
    logic [PBC_CNT_W-1:0] half_cyc;
    logic                 flash_wrap;
    logic                 flash_restart;

    assign half_cyc   = FLASH_HALF_CYC[flash_idx*PBC_CNT_W +: PBC_CNT_W];         // [RULE_18]
    assign flash_wrap = (flash_cnt_ff >= half_cyc - PBC_CNT_W'(1));
    assign flash_restart = !sel_flash || wr_hit;

    // wave restarts high on every write so a new rate starts from a clean edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_cnt_ff <= '0;
        end else if (flash_restart || flash_wrap) begin
            flash_cnt_ff <= '0;
        end else begin
            flash_cnt_ff <= flash_cnt_ff + PBC_CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_wave_ff <= 1'b1;
        end else if (flash_restart) begin
            flash_wave_ff <= 1'b1;
        end else if (flash_wrap) begin
            flash_wave_ff <= ~flash_wave_ff;                                       // [RULE_02]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin output drive

    logic wave;
    logic bc_out;
    logic bc_oe_n;
    logic nxt_pin_out;
    logic nxt_pin_oe_n;
    logic pin_out_ff;
    logic pin_oe_n_ff;
    logic pullup_ff;
    logic nxt_pullup;

    assign wave = (drive_mode == PBC_DRV_TRAIN) ? pulse_train_in[ctl_fs] : flash_wave_ff;   // [RULE_16]

    always_comb begin
        bc_out  = 1'b1;
        bc_oe_n = 1'b1;
        unique case (drive_mode)
            PBC_DRV_INPUT: begin
                bc_out  = 1'b1;
                bc_oe_n = 1'b1;                                                    // [RULE_06]
            end
            PBC_DRV_STEADY: begin
                bc_out  = ctl_gpd;                                                 // [RULE_12]
                bc_oe_n = 1'b0;
            end
            // high side only when gpd is set, low side only when clear
            PBC_DRV_FLASH, PBC_DRV_TRAIN: begin
                if (ctl_gpd) begin
                    bc_out  = 1'b1;                                                // [RULE_04]
                    bc_oe_n = ~wave;
                end else begin
                    bc_out  = 1'b0;                                                // [RULE_04]
                    bc_oe_n = wave;
                end
            end
            default: begin
                bc_out  = 1'b1;
                bc_oe_n = 1'b1;
            end
        endcase
    end

    // a higher-priority function takes the pin outright
    assign nxt_pin_out  = override_en ? override_out  : bc_out;                    // [RULE_17]
    assign nxt_pin_oe_n = override_en ? override_oe_n : bc_oe_n;                   // [RULE_17]
    assign nxt_pullup   = ctl_dd && !override_en;                                  // [RULE_14]

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_ff <= 1'b1;
        end else begin
            pin_out_ff <= nxt_pin_out;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_oe_n_ff <= 1'b1;                                                   // [RULE_11]
        end else begin
            pin_oe_n_ff <= nxt_pin_oe_n;
        end
    end

    // pull-up only while the pin is an input and not overridden
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pullup_ff <= 1'b1;
        end else begin
            pullup_ff <= nxt_pullup;                                               // [RULE_14]
        end
    end

    assign pin_out       = pin_out_ff;
    assign pin_oe_n      = pin_oe_n_ff;
    assign pin_pullup_en = pullup_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // input edge interrupt

    logic       filt_rise;
    logic       filt_fall;
    logic       filt_rearm;
    logic [1:0] edge_en;
    logic       int_armed;
    logic       int_event;
    logic       int_pend_ff;
    logic [7:0] int_src_ff;
    logic       src_load_ff;

    // rearm hides edges while driving, while overridden and on a direction write
    assign filt_rearm = !ctl_dd || override_en || dir_change;                      // [RULE_09]

    pbc_edge_filter #(
        .FILT_CYC   (FILT_CYC)
    ) u_filter (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .level_in   (pin_sync_ff),
        .rearm      (filt_rearm),
        .filt_level (),
        .rise_pulse (filt_rise),
        .fall_pulse (filt_fall)
    );                                                                             // [RULE_08]

    assign edge_en   = EDGE_TABLE[{ctl_fs, 1'b0} +: 2];                            // [RULE_07] [RULE_18]
    assign int_armed = ctl_dd && !override_en;
    assign int_event = int_armed && ((filt_rise && edge_en[1]) || (filt_fall && edge_en[0]));  // [RULE_07]

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_load_ff <= 1'b0;
        end else begin
            src_load_ff <= int_event;
        end
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_pend_ff <= 1'b0;
        end else if (int_event) begin
            int_pend_ff <= 1'b1;                                                   // [RULE_08]
        end else if (int_clear) begin
            int_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_src_ff <= 8'h00;
        end else if (int_event) begin
            int_src_ff <= MY_ADDR;                                                 // [RULE_08]
        end
    end

    assign int_n        = ~int_pend_ff;                                            // [RULE_08]
    assign int_src      = int_src_ff;
    assign int_src_load = src_load_ff;

endmodule

// [pbc_pin_ctrl_asserts.sv]
// concurrent checks on the per-pin bit control ports
`timescale 1ns/10ps
module pbc_pin_ctrl_asserts
    import pbc_pkg::*;
#(
    parameter logic [2:0] PIN_INDEX = 3'h0
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rd_valid,
    input  wire logic       override_en,
    input  wire logic       override_out,
    input  wire logic       override_oe_n,
    input  wire logic       pin_out,
    input  wire logic       pin_oe_n,
    input  wire logic       pin_pullup_en,
    input  wire logic       int_clear,
    input  wire logic       int_n,
    input  wire logic [7:0] int_src,
    input  wire logic       int_src_load
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire [7:0] hit_addr = PBC_BASE_ADDR + {5'h00, PIN_INDEX};
    wire       wr_hit   = reg_wr_en && (reg_addr == hit_addr);
    wire       rd_hit   = reg_rd_en && (reg_addr == hit_addr);
    ////////////////////////////////////////////////////////////////////////
    rd_answer_a: assert property (reg_rd_valid == $past(rd_hit))
        else $error("read answer pulse wrong");
    miss_quiet_a: assert property (!$past(rd_hit) |-> reg_rdata == 8'h00)
        else $error("read data not zero without hit");
    dir_input_a: assert property (wr_hit && reg_wdata[1] ##1 !override_en |=> pin_oe_n)
        else $error("input mode still drives");
    drive_low_a: assert property (wr_hit && reg_wdata == 8'h00 ##1 !override_en |=> !pin_oe_n && !pin_out)
        else $error("steady low drive missing");
    pullup_input_a: assert property (pin_pullup_en |-> pin_oe_n)
        else $error("pull-up on while driving");
    override_wins_a: assert property ($past(override_en) |->
        pin_out == $past(override_out) && pin_oe_n == $past(override_oe_n))
        else $error("override not followed");
    src_load_a: assert property ($fell(int_n) |-> int_src == hit_addr && int_src_load)
        else $error("source address or load pulse wrong");
    int_hold_a: assert property (!int_n && !int_clear |=> !int_n)
        else $error("interrupt released without clear");
    cover property ($fell(int_n));
    cover property (rd_hit ##1 reg_rd_valid);
    cover property ($rose(pin_oe_n) ##[1:20] $fell(pin_oe_n));
endmodule
bind pbc_pin_ctrl pbc_pin_ctrl_asserts #(.PIN_INDEX(PIN_INDEX)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .override_en(override_en),
    .override_out(override_out), .override_oe_n(override_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pullup_en), .int_clear(int_clear), .int_n(int_n), .int_src(int_src),
    .int_src_load(int_src_load));

// [pbc_pin_partner.sv]
// led or external source on the pad
`timescale 1ns/10ps
module pbc_pin_partner (
    input  wire logic core_clk,
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    input  wire logic pin_pullup_en,
    input  wire logic ext_en,
    input  wire logic ext_val,
    output logic      pin_lvl
);
    logic last_ff;
    always_ff @(posedge core_clk) begin
        last_ff <= pin_lvl;
    end
    // undriven pad without pull-up drifts away from its last level
    assign pin_lvl = !pin_oe_n ? pin_out : ext_en ? ext_val : pin_pullup_en ? 1'b1 : ~last_ff;
endmodule

// [pbc_pin_ctrl_tb_top.sv]
// self-checking bench for the per-pin bit control
`timescale 1ns/10ps
module pbc_pin_ctrl_tb_top;
    import pbc_pkg::*;
    localparam logic [2:0] PIN_IX = 3'h2;
    localparam logic [7:0] HIT    = 8'hc2;
    logic       core_clk, rst_n, reg_wr_en, reg_rd_en, override_en, override_out, override_oe_n;
    logic       int_clear, ext_en, ext_val, reg_rd_valid, pin_out, pin_oe_n, pin_pullup_en;
    logic       int_n, int_src_load, pin_lvl, v;
    logic [7:0] reg_addr, reg_wdata, pt_in, reg_rdata, int_src, d;
    int         error_cnt, n_compared, n, i;
    pbc_pin_ctrl #(.PIN_INDEX(PIN_IX), .FILT_CYC(2),
        .FLASH_HALF_CYC({24'd10, 24'd9, 24'd8, 24'd7, 24'd6, 24'd5, 24'd4})) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .pulse_train_in(pt_in), .override_en(override_en), .override_out(override_out),
        .override_oe_n(override_oe_n), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup_en(pin_pullup_en), .int_clear(int_clear), .int_n(int_n), .int_src(int_src),
        .int_src_load(int_src_load));
    pbc_pin_partner u_pin (.core_clk(core_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));
    ////////////////////////////////////////////////////////////////////////
    task step(input int c);
        repeat (c) @(posedge core_clk) #1;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] w);
        reg_wr_en = 1; reg_addr = a; reg_wdata = w;
        step(1);
        reg_wr_en = 0;
    endtask
    task rd(input logic [7:0] a);
        reg_rd_en = 1; reg_addr = a;
        step(1);
        d = reg_rdata; v = reg_rd_valid;
        reg_rd_en = 0;
        step(1);
    endtask
    task meas;
        v = pin_oe_n;
        for (i = 0; i < 40 && pin_oe_n === v; i++) step(1);
        v = pin_oe_n; n = 0;
        for (i = 0; i < 40 && pin_oe_n === v; i++) begin step(1); n++; end
    endtask
    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        chk(pin_oe_n, 1); chk(pin_pullup_en, 1); chk(int_n, 1);
        rd(HIT); chk(d, 8'h03); chk(v, 1);
        rd(HIT + 8'h01); chk(d, 8'h00); chk(v, 0);
        wr(HIT + 8'h01, 8'h00); step(2); chk(pin_oe_n, 1);
        $display("test reset done");
    endtask
    task t_output;
        wr(HIT, 8'h00); step(2); chk(pin_out, 0); chk(pin_oe_n, 0);
        rd(HIT); chk(d, 8'h00);
        wr(HIT, 8'h61); step(2); chk(pin_out, 1); rd(HIT); chk(d, 8'h01);
        $display("test output done");
    endtask
    task t_input;
        wr(HIT, 8'h00); step(2); chk(pin_lvl, 0);
        wr(HIT, 8'h02); step(4); chk(pin_oe_n, 1); chk(pin_lvl, 1);
        rd(HIT); chk(d, 8'h03);
        ext_en = 1; ext_val = 0; step(4); rd(HIT); chk(d, 8'h02);
        ext_en = 0; step(4);
        $display("test input done");
    endtask
    task t_flash;
        for (int k = 1; k < 8; k++) begin
            wr(HIT, {3'b000, 3'(k), 2'b01}); step(2); chk(pin_out, 1);
            meas; chk(8'(n), 8'(k + 3));
        end
        wr(HIT, 8'h04); step(2); chk(pin_out, 0); meas; chk(8'(n), 8'h04);
        $display("test flash done");
    endtask
    task t_train;
        for (int t = 0; t < 8; t++) begin
            pt_in = 8'h01 << t; wr(HIT, {3'b100, 3'(t), 2'b01}); step(2); chk(pin_oe_n, 0);
            pt_in = ~pt_in; step(2); chk(pin_oe_n, 1);
        end
        $display("test train done");
    endtask
    task t_override;
        wr(HIT, 8'h03); override_en = 1; override_out = 0; override_oe_n = 0;
        step(2); chk(pin_out, 0); chk(pin_oe_n, 0); chk(pin_pullup_en, 0);
        override_en = 0; step(2); chk(pin_oe_n, 1);
        $display("test override done");
    endtask
    task t_irq;
        wr(HIT, 8'h0b); step(4); ext_en = 1; ext_val = 0;
        for (i = 0; i < 20 && int_n !== 1'b0; i++) step(1);
        chk(int_n, 0); chk(int_src, HIT); chk(int_src_load, 1);
        step(1); chk(int_src_load, 0);
        int_clear = 1; step(1); int_clear = 0; chk(int_n, 1);
        ext_val = 1; step(10); chk(int_n, 1); ext_en = 0;
        wr(HIT, 8'h07); step(4); ext_en = 1; ext_val = 0; step(10); chk(int_n, 1);
        ext_val = 1;
        for (i = 0; i < 20 && int_n !== 1'b0; i++) step(1);
        chk(int_n, 0);
        int_clear = 1; step(1); int_clear = 0; ext_en = 0; chk(int_n, 1);
        $display("test interrupt done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        wrap_up;
    end
    initial begin
        error_cnt = 0; n_compared = 0; rst_n = 0; reg_wr_en = 0; reg_rd_en = 0; reg_addr = 8'h00;
        reg_wdata = 8'h00; pt_in = 8'h00; override_en = 0; override_out = 0; override_oe_n = 1;
        int_clear = 0; ext_en = 0; ext_val = 1;
        repeat (4) @(posedge core_clk);
        #1 rst_n = 1;
        step(1);
        t_reset; t_output; t_input; t_flash; t_train; t_override;
        wr(HIT, 8'h03); step(1); t_irq;
        wrap_up;
    end
endmodule
